// ===== logic/rcs_divider.sv
`timescale 1ns/1ps
module rcs_divider
  import rcs_pkg::*;
#(
  parameter int W = RCS_DIV_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic base_tick_i,
  input wire logic run_i,
  input wire logic [3:0] code_i,
  output logic div_o
);
  // base_tick_i marks every base-clock edge, so counter bit n toggles at base/2^n
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (!run_i) begin
      cnt_nxt = '0;
      out_nxt = 1'b0;
    end else if (base_tick_i) begin
      cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
      // code 0 passes the base, code n divides by 2^n (code 2 is divide by four)
      out_nxt = cnt_nxt[code_i];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end
  assign div_o = out_r;
endmodule

// ===== logic/rcs_pkg.sv
package rcs_pkg;
  // ==========================================================
  // register map (byte addresses on the AXI4-Lite port)
  localparam logic [3:0] RCS_ADDR_REFOUT_CTRL = 4'h0;
  localparam logic [3:0] RCS_ADDR_PWR_CTRL = 4'h4;
  localparam logic [3:0] RCS_ADDR_PWR_STATUS = 4'h8;
  // ==========================================================
  // reference output control fields
  localparam int RCS_BIT_REFOUT_ENABLE = 15;
  localparam int RCS_BIT_REFOUT_SLEEP_RUN = 13;
  localparam int RCS_BIT_REFOUT_SOURCE_SELECT = 12;
  localparam int RCS_DIV_LSB = 8;
  localparam logic [15:0] RCS_REFOUT_CTRL_RESET = 16'h0000;
  localparam logic [15:0] RCS_REFOUT_CTRL_MASK = 16'hbf00;
  // ==========================================================
  // power control fields
  localparam int RCS_BIT_WDT_EN = 0;
  localparam int RCS_BIT_FAIL_SAFE_CLOCK_MONITOR_EN = 1;
  localparam int RCS_BIT_REG_SLEEP_KEEP = 2;
  localparam int RCS_BIT_POSC_SLEEP_KEEP = 3;
  localparam int RCS_BIT_POSC_MODE = 4;
  localparam int RCS_BIT_SYSCLK_ONCHIP = 5;
  localparam logic [5:0] RCS_PWR_CTRL_RESET = 6'h04;
  // ==========================================================
  // timing
  localparam int RCS_CLK_HZ = 20000000;
  localparam int RCS_REG_WAKE_US = 190;
  localparam int RCS_REG_WAKE_CYC = (RCS_REG_WAKE_US * (RCS_CLK_HZ / 1000000));
  localparam int RCS_DIV_W = 16;
  typedef enum logic [3:0] {
    RCS_RUN = 4'h1,
    RCS_IDLE = 4'h2,
    RCS_SLEEP = 4'h4,
    RCS_WAKE = 4'h8
  } rcs_state_t;
endpackage

// ===== logic/rcs_regfile.sv
`timescale 1ns/1ps
module rcs_regfile
  import rcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic rd_i,
  input wire logic [3:0] raddr_i,
  input wire logic [31:0] status_i,
  output logic [15:0] refout_ctrl_o,
  output logic [5:0] pwr_ctrl_o,
  output logic [31:0] rdata_o,
  output logic rerr_o,
  output logic werr_o
);
  logic [15:0] ref_r, ref_nxt;
  logic [5:0] pwr_r, pwr_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rerr_r, rerr_nxt, werr_nxt;
  always_comb begin
    ref_nxt = ref_r;
    pwr_nxt = pwr_r;
    werr_nxt = 1'b0;
    if (wr_i) begin
      if (waddr_i == RCS_ADDR_REFOUT_CTRL) begin
        // unimplemented bits stay zero
        if (wstrb_i[1]) ref_nxt[15:8] = wdata_i[15:8] & RCS_REFOUT_CTRL_MASK[15:8];
      end else if (waddr_i == RCS_ADDR_PWR_CTRL) begin
        if (wstrb_i[0]) pwr_nxt = wdata_i[5:0];
      end else if (waddr_i != RCS_ADDR_PWR_STATUS) begin
        werr_nxt = 1'b1;
      end
    end
    rd_nxt = rd_r;
    rerr_nxt = rerr_r;
    if (rd_i) begin
      rerr_nxt = 1'b0;
      if (raddr_i == RCS_ADDR_REFOUT_CTRL) begin
        rd_nxt = {16'h0000, ref_r};
      end else if (raddr_i == RCS_ADDR_PWR_CTRL) begin
        rd_nxt = {26'h0, pwr_r};
      end else if (raddr_i == RCS_ADDR_PWR_STATUS) begin
        rd_nxt = status_i;
      end else begin
        rd_nxt = 32'h0;
        rerr_nxt = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_r <= RCS_REFOUT_CTRL_RESET;
      pwr_r <= RCS_PWR_CTRL_RESET;
      rd_r <= 32'h0;
      rerr_r <= 1'b0;
    end else begin
      ref_r <= ref_nxt;
      pwr_r <= pwr_nxt;
      rd_r <= rd_nxt;
      rerr_r <= rerr_nxt;
    end
  end
  assign refout_ctrl_o = ref_r;
  assign pwr_ctrl_o = pwr_r;
  assign rdata_o = rd_r;
  assign rerr_o = rerr_r;
  assign werr_o = werr_nxt;
endmodule

// ===== logic/rcs_top.sv
`timescale 1ns/1ps
// Operation
// - enable bit drives divided clock on pin
// - divisor code n divides base by 2^n
// - source select picks primary oscillator or sysclk
// - sleep-run bit keeps output alive in sleep
// - sleep output needs both bits and primary mode
// - control bits reset zero except regulator sleep keep (resets one), unused read zero
// - half-rate clock pin runs at osc/2
// - instruction #0 sleeps, #1 idles
// - sleep stops system clock, and on-chip osc when it is the sysclk source
// - sleep keeps low-power RC while watchdog on
// - watchdog cleared just before sleep entry
// - clock monitor inactive during sleep
// - sysclk peripherals off in sleep
// - regulator off in sleep adds 190us wake
// - sleep exits on interrupt, reset, watchdog
// - sleep wake resumes the previous clock source
// - idle halts cpu, clears watchdog, clock runs
// - idle keeps RC if watchdog or monitor on
// - idle exits on interrupt, reset, watchdog
// - idle wake resumes cpu without delay
// - interrupt during entry defers, then wakes
module rcs_top
  import rcs_pkg::*;
#(
  parameter int REG_WAKE_CYC = RCS_REG_WAKE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ==========================================================
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // ==========================================================
  // clock tick inputs and power-save request
  input wire logic posc_tick_i,
  input wire logic sysclk_tick_i,
  input wire logic pwr_save_i,
  input wire logic pwr_save_arg_i,
  input wire logic irq_wake_i,
  input wire logic wdt_timeout_i,
  // ==========================================================
  // outputs
  output logic reference_clock_pin_o,
  output logic half_rate_clock_pin_o,
  output logic cpu_clk_en_o,
  output logic sysclk_en_o,
  output logic onchip_osc_en_o,
  output logic posc_en_o,
  output logic low_power_rc_osc_en_o,
  output logic fail_safe_clock_monitor_active_o,
  output logic periph_clk_en_o,
  output logic wdt_clear_o,
  output logic regulator_en_o,
  output logic wake_resume_o
);
  // ==========================================================
  // bus slave: address and data taken in either order
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic [3:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt, rpend_r, rpend_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_wr, do_rd, rerr, werr;
  logic [31:0] rdata;
  logic [15:0] refout_ctrl;
  logic [5:0] pwr_ctrl;
  logic [31:0] status;
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    do_wr = 1'b0;
    if (s_axi_awvalid && !aw_got_r && !bvalid_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r && !bvalid_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_got_r && w_got_r) begin
      do_wr = 1'b1;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = werr ? 2'b10 : 2'b00;
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    rpend_nxt = 1'b0;
    rvalid_nxt = rvalid_r;
    do_rd = s_axi_arvalid && !rvalid_r && !rpend_r;
    if (do_rd) rpend_nxt = 1'b1;
    if (rpend_r) rvalid_nxt = 1'b1;
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt && !rpend_nxt;
    rresp_nxt = rerr ? 2'b10 : 2'b00;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rpend_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      rresp_r <= 2'b00;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rpend_r <= rpend_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp_r;

  rcs_regfile u_regs (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(do_wr),
    .waddr_i(awaddr_r),
    .wdata_i(wdata_r),
    .wstrb_i(wstrb_r),
    .rd_i(do_rd),
    .raddr_i(s_axi_araddr),
    .status_i(status),
    .refout_ctrl_o(refout_ctrl),
    .pwr_ctrl_o(pwr_ctrl),
    .rdata_o(rdata),
    .rerr_o(rerr),
    .werr_o(werr)
  );

  // ==========================================================
  // power-save state machine
  rcs_state_t st_r, st_nxt;
  logic [15:0] wake_cnt_r, wake_cnt_nxt;
  logic wdt_clr_r, wdt_clr_nxt, resume_r, resume_nxt, defer_r, defer_nxt;
  logic wake_ev;
  logic wdt_en, fail_safe_clock_monitor_en, reg_keep, posc_keep, posc_mode, sys_onchip;
  assign wdt_en = pwr_ctrl[RCS_BIT_WDT_EN];
  assign fail_safe_clock_monitor_en = pwr_ctrl[RCS_BIT_FAIL_SAFE_CLOCK_MONITOR_EN];
  assign reg_keep = pwr_ctrl[RCS_BIT_REG_SLEEP_KEEP];
  assign posc_keep = pwr_ctrl[RCS_BIT_POSC_SLEEP_KEEP];
  assign posc_mode = pwr_ctrl[RCS_BIT_POSC_MODE];
  assign sys_onchip = pwr_ctrl[RCS_BIT_SYSCLK_ONCHIP];
  // reset wakes by clearing everything, so only interrupts and timeouts appear here
  assign wake_ev = irq_wake_i || wdt_timeout_i || defer_r;
  always_comb begin
    st_nxt = st_r;
    wake_cnt_nxt = wake_cnt_r;
    wdt_clr_nxt = 1'b0;
    resume_nxt = 1'b0;
    defer_nxt = 1'b0;
    case (st_r)
      RCS_RUN: begin
        if (pwr_save_i) begin
          // an interrupt coincident with entry is held and wakes right after
          defer_nxt = irq_wake_i;
          wdt_clr_nxt = wdt_en;
          st_nxt = pwr_save_arg_i ? RCS_IDLE : RCS_SLEEP;
        end
      end
      RCS_IDLE: begin
        if (wake_ev) begin
          resume_nxt = 1'b1;
          st_nxt = RCS_RUN;
        end
      end
      RCS_SLEEP: begin
        if (wake_ev) begin
          // regulator restart costs extra wake time when it was turned off
          wake_cnt_nxt = reg_keep ? 16'h0 : 16'(REG_WAKE_CYC);
          st_nxt = RCS_WAKE;
        end
      end
      RCS_WAKE: begin
        if (wake_cnt_r == 16'h0) begin
          resume_nxt = 1'b1;
          st_nxt = RCS_RUN;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 16'h1;
        end
      end
      default: st_nxt = RCS_RUN;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= RCS_RUN;
      wake_cnt_r <= 16'h0;
      wdt_clr_r <= 1'b0;
      resume_r <= 1'b0;
      defer_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      wdt_clr_r <= wdt_clr_nxt;
      resume_r <= resume_nxt;
      defer_r <= defer_nxt;
    end
  end

  // ==========================================================
  // clock gating outputs
  logic in_sleep, in_idle, in_low;
  logic refout_run, ref_base_tick, ref_div;
  logic cpu_en_r, sys_en_r, onchip_r, posc_r, low_power_rc_osc_r, fail_safe_clock_monitor_r, per_r, reg_r, refpin_r, half_r;
  logic cpu_en_nxt, sys_en_nxt, onchip_nxt, posc_nxt, low_power_rc_osc_nxt, fail_safe_clock_monitor_nxt, per_nxt, reg_nxt, refpin_nxt, half_nxt;
  logic half_ph_r, half_ph_nxt;
  assign in_sleep = (st_r == RCS_SLEEP) || (st_r == RCS_WAKE);
  assign in_idle = (st_r == RCS_IDLE);
  assign in_low = in_sleep || in_idle;
  // sleep output only when primary oscillator is selected and actually running
  assign refout_run = refout_ctrl[RCS_BIT_REFOUT_ENABLE] && (!in_sleep ||
    (refout_ctrl[RCS_BIT_REFOUT_SLEEP_RUN] && refout_ctrl[RCS_BIT_REFOUT_SOURCE_SELECT] && posc_mode));
  assign ref_base_tick = refout_ctrl[RCS_BIT_REFOUT_SOURCE_SELECT] ? posc_tick_i : sysclk_tick_i;
  always_comb begin
    cpu_en_nxt = !in_low;
    sys_en_nxt = !in_sleep;
    onchip_nxt = !(in_sleep && sys_onchip);
    posc_nxt = !in_sleep || posc_keep || (refout_run && posc_mode);
    low_power_rc_osc_nxt = in_sleep ? wdt_en : (wdt_en || fail_safe_clock_monitor_en);
    fail_safe_clock_monitor_nxt = fail_safe_clock_monitor_en && !in_sleep;
    per_nxt = !in_sleep;
    reg_nxt = !(in_sleep && !reg_keep);
    refpin_nxt = ref_div && refout_run;
    half_ph_nxt = (posc_tick_i && !in_sleep) ? ~half_ph_r : half_ph_r;
    half_nxt = (posc_tick_i && !in_sleep && half_ph_r) ? ~half_r : half_r;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_en_r <= 1'b1;
      sys_en_r <= 1'b1;
      onchip_r <= 1'b1;
      posc_r <= 1'b1;
      low_power_rc_osc_r <= 1'b0;
      fail_safe_clock_monitor_r <= 1'b0;
      per_r <= 1'b1;
      reg_r <= 1'b1;
      refpin_r <= 1'b0;
      half_r <= 1'b0;
      half_ph_r <= 1'b0;
    end else begin
      cpu_en_r <= cpu_en_nxt;
      sys_en_r <= sys_en_nxt;
      onchip_r <= onchip_nxt;
      posc_r <= posc_nxt;
      low_power_rc_osc_r <= low_power_rc_osc_nxt;
      fail_safe_clock_monitor_r <= fail_safe_clock_monitor_nxt;
      per_r <= per_nxt;
      reg_r <= reg_nxt;
      refpin_r <= refpin_nxt;
      half_r <= half_nxt;
      half_ph_r <= half_ph_nxt;
    end
  end

  rcs_divider u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .base_tick_i(ref_base_tick),
    .run_i(refout_run),
    .code_i(refout_ctrl[RCS_DIV_LSB+3:RCS_DIV_LSB]),
    .div_o(ref_div)
  );

  assign status = {24'h0, in_sleep, in_idle, refout_run, 1'b0, st_r};
  assign reference_clock_pin_o = refpin_r;
  assign half_rate_clock_pin_o = half_r;
  assign cpu_clk_en_o = cpu_en_r;
  assign sysclk_en_o = sys_en_r;
  assign onchip_osc_en_o = onchip_r;
  assign posc_en_o = posc_r;
  assign low_power_rc_osc_en_o = low_power_rc_osc_r;
  assign fail_safe_clock_monitor_active_o = fail_safe_clock_monitor_r;
  assign periph_clk_en_o = per_r;
  assign wdt_clear_o = wdt_clr_r;
  assign regulator_en_o = reg_r;
  assign wake_resume_o = resume_r;

  // ==========================================================
  // checks
  property p_sleep_entry;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == RCS_RUN && pwr_save_i && !pwr_save_arg_i) |=> (st_r == RCS_SLEEP) ##1 !sys_en_r;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_idle_entry;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == RCS_RUN && pwr_save_i && pwr_save_arg_i) |=> (st_r == RCS_IDLE) ##1 (!cpu_en_r && sys_en_r);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle gating wrong");
  property p_wdt_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == RCS_RUN && pwr_save_i && wdt_en) |=> wdt_clr_r;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");
  property p_sleep_low_power_rc_osc;
    @(posedge clk_i) disable iff (!rst_n_i)
    ($past(st_r) == RCS_SLEEP && st_r == RCS_SLEEP) |-> (low_power_rc_osc_r == wdt_en && !fail_safe_clock_monitor_r);
  endproperty
  a_sleep_low_power_rc_osc: assert property (p_sleep_low_power_rc_osc) else $error("rc or monitor wrong in sleep");
  property p_idle_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == RCS_IDLE && irq_wake_i) |=> (st_r == RCS_RUN && resume_r) ##1 cpu_en_r;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake slow");
  property p_defer;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == RCS_RUN && pwr_save_i && pwr_save_arg_i && irq_wake_i) |=> ##1 (st_r == RCS_RUN);
  endproperty
  a_defer: assert property (p_defer) else $error("deferred wake lost");
  property p_refout_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    !refout_ctrl[RCS_BIT_REFOUT_ENABLE] |=> !reference_clock_pin_o;
  endproperty
  a_refout_off: assert property (p_refout_off) else $error("ref pin active while off");
  property p_reg_fast;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_r == RCS_SLEEP && wake_ev && reg_keep) |=> ##1 (st_r == RCS_RUN);
  endproperty
  a_reg_fast: assert property (p_reg_fast) else $error("sleep wake delayed");
  property p_ctrl_unused;
    @(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |-> (refout_ctrl[14] == 1'b0 && refout_ctrl[7:0] == 8'h00);
  endproperty
  a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused bits set");
endmodule

// ===== test/rcs_refout_load.sv
`timescale 1ns/1ps
// ==========================================================
// far side: crystal source and a load timing both clock pins
module rcs_refout_load #(
  parameter int POSC_PER = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reference_clock_pin_i,
  input wire logic half_rate_clock_pin_i,
  output logic posc_tick_o,
  output logic [31:0] ref_half_o,
  output logic [31:0] half_rate_half_o
);
  logic [7:0] ph_r;
  logic ref_q_r;
  logic hr_q_r;
  logic [31:0] ref_cnt_r;
  logic [31:0] hr_cnt_r;

  // the crystal keeps running, so ticks are not gated by the device state
  assign posc_tick_o = (ph_r == 8'h00);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ph_r <= 8'h00;
      ref_q_r <= 1'b0;
      hr_q_r <= 1'b0;
      ref_cnt_r <= 32'h0;
      hr_cnt_r <= 32'h0;
      ref_half_o <= 32'h0;
      half_rate_half_o <= 32'h0;
    end else begin
      ph_r <= (ph_r == 8'(POSC_PER - 1)) ? 8'h00 : ph_r + 8'h01;
      ref_q_r <= reference_clock_pin_i;
      hr_q_r <= half_rate_clock_pin_i;
      // half period in system cycles, taken between two level changes
      if (reference_clock_pin_i != ref_q_r) begin
        ref_half_o <= ref_cnt_r;
        ref_cnt_r <= 32'h1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 32'h1;
      end
      if (half_rate_clock_pin_i != hr_q_r) begin
        half_rate_half_o <= hr_cnt_r;
        hr_cnt_r <= 32'h1;
      end else begin
        hr_cnt_r <= hr_cnt_r + 32'h1;
      end
    end
  end
endmodule

// ===== test/refclk_out_and_sleep_idle_ctrl_bench.sv
`timescale 1ns/1ps
module refclk_out_and_sleep_idle_ctrl_bench;
  import rcs_pkg::*;
  localparam int REG_WAKE = 5;
  logic clk_i, rst_n_i;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ref_half, hr_half, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic posc_tick_i, sysclk_tick_i, pwr_save_i, pwr_save_arg_i, irq_wake_i, wdt_timeout_i;
  logic reference_clock_pin_o, half_rate_clock_pin_o, cpu_clk_en_o, sysclk_en_o, onchip_osc_en_o;
  logic posc_en_o, low_power_rc_osc_en_o, fail_safe_clock_monitor_active_o, periph_clk_en_o, wdt_clear_o;
  logic regulator_en_o, wake_resume_o, clr_seen, cpu_off_seen;
  int errors, comparisons, wake_at, tog;

  rcs_top #(.REG_WAKE_CYC(REG_WAKE)) rcs_top_i (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .posc_tick_i, .sysclk_tick_i, .pwr_save_i, .pwr_save_arg_i, .irq_wake_i, .wdt_timeout_i,
    .reference_clock_pin_o, .half_rate_clock_pin_o, .cpu_clk_en_o, .sysclk_en_o, .onchip_osc_en_o,
    .posc_en_o, .low_power_rc_osc_en_o, .fail_safe_clock_monitor_active_o, .periph_clk_en_o, .wdt_clear_o,
    .regulator_en_o, .wake_resume_o);

  rcs_refout_load #(.POSC_PER(3)) rcs_refout_load_i (.clk_i, .rst_n_i,
    .reference_clock_pin_i(reference_clock_pin_o), .half_rate_clock_pin_i(half_rate_clock_pin_o),
    .posc_tick_o(posc_tick_i), .ref_half_o(ref_half), .half_rate_half_o(hr_half));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] refv(input logic en, input logic slp, input logic sel, input logic [3:0] dv);
    return {16'h0, en, 1'b0, slp, sel, dv, 8'h00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // bus master: decide at the falling edge, act right after the rising edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pb && n < 100) begin
      @(negedge clk_i);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) resp = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      pb = !tb;
      n++;
    end
    if (pb) chk(32'h0, 32'h1, "write got no response");
  endtask

  task automatic axi_rd(input logic [3:0] a);
    logic pa, pr, ta, tr;
    int n;
    pa = 1'b1;
    pr = 1'b1;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pr && n < 100) begin
      @(negedge clk_i);
      ta = pa && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) rd = s_axi_rdata;
      if (tr) resp = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      pa = pa && !ta;
      pr = !tr;
      n++;
    end
    if (pr) chk(32'h0, 32'h1, "read got no response");
  endtask

  // ==========================================================
  // power-state helpers
  task automatic watch(input int n);
    logic p;
    clr_seen = 1'b0;
    cpu_off_seen = 1'b0;
    wake_at = 0;
    tog = 0;
    p = reference_clock_pin_o;
    for (int i = 1; i <= n; i++) begin
      @(negedge clk_i);
      if (wdt_clear_o === 1'b1) clr_seen = 1'b1;
      if (cpu_clk_en_o === 1'b0) cpu_off_seen = 1'b1;
      if (wake_resume_o === 1'b1 && wake_at == 0) wake_at = i;
      if (reference_clock_pin_o !== p) tog++;
      p = reference_clock_pin_o;
    end
  endtask

  task automatic save(input logic arg, input logic with_irq);
    @(posedge clk_i);
    pwr_save_i <= 1'b1;
    pwr_save_arg_i <= arg;
    irq_wake_i <= with_irq;
    @(posedge clk_i);
    pwr_save_i <= 1'b0;
    watch(8);
    @(posedge clk_i);
    irq_wake_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic wake(input logic by_wdt);
    @(posedge clk_i);
    if (by_wdt) wdt_timeout_i <= 1'b1;
    else irq_wake_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    watch(40);
    @(posedge clk_i);
    irq_wake_i <= 1'b0;
    @(negedge clk_i);
  endtask

  // ==========================================================
  // tests
  initial begin
    rst_n_i = 1'b0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    sysclk_tick_i = 1'b1;
    {pwr_save_i, pwr_save_arg_i, irq_wake_i, wdt_timeout_i} = '0;
    errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    axi_rd(RCS_ADDR_REFOUT_CTRL);
    chk(rd, 32'h0, "refout ctrl reset");
    axi_rd(RCS_ADDR_PWR_CTRL);
    chk(rd, 32'h4, "power ctrl reset");
    axi_wr(RCS_ADDR_PWR_STATUS, 32'hffff_ffff, 4'hf);
    chk({30'h0, resp}, 32'h0, "status write response");
    axi_rd(RCS_ADDR_PWR_STATUS);
    chk(rd, 32'h1, "status after reset");
    axi_wr(RCS_ADDR_REFOUT_CTRL, 32'hffff_ffff, 4'hf);
    axi_rd(RCS_ADDR_REFOUT_CTRL);
    chk(rd, 32'h0000_bf00, "refout ctrl unused bits");
    axi_wr(4'hc, 32'hffff_ffff, 4'hf);
    chk({30'h0, resp}, 32'h2, "unmapped write response");
    axi_rd(4'hc);
    chk({rd[29:0], resp}, 32'h2, "unmapped read");
    $display("test registers done");
    for (int c = 0; c < 7; c++) begin
      axi_wr(RCS_ADDR_REFOUT_CTRL, refv(1'b1, 1'b0, 1'b0, 4'(c)), 4'h2);
      repeat ((4 << c) + 8) @(posedge clk_i);
      @(negedge clk_i);
      chk(ref_half, 32'h1 << c, "half period from system clock");
    end
    axi_wr(RCS_ADDR_REFOUT_CTRL, refv(1'b1, 1'b0, 1'b1, 4'h1), 4'h2);
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    chk(ref_half, 32'h6, "half period from crystal");
    chk(hr_half, 32'h6, "half-rate pin period");
    axi_wr(RCS_ADDR_REFOUT_CTRL, refv(1'b0, 1'b0, 1'b0, 4'h0), 4'h2);
    repeat (4) @(posedge clk_i);
    watch(20);
    chk({31'h0, reference_clock_pin_o} | 32'(tog), 32'h0, "disabled pin quiet");
    $display("test divider done");
    axi_wr(RCS_ADDR_PWR_CTRL, 32'h37, 4'h1);
    axi_wr(RCS_ADDR_REFOUT_CTRL, refv(1'b1, 1'b1, 1'b1, 4'h1), 4'h2);
    @(negedge clk_i);
    chk({31'h0, fail_safe_clock_monitor_active_o}, 32'h1, "monitor running");
    save(1'b0, 1'b0);
    chk({31'h0, clr_seen}, 32'h1, "watchdog cleared on sleep");
    @(negedge clk_i);
    chk({cpu_clk_en_o, sysclk_en_o, onchip_osc_en_o, periph_clk_en_o, fail_safe_clock_monitor_active_o}, 32'h0, "sleep gating");
    chk({low_power_rc_osc_en_o, regulator_en_o, posc_en_o}, 32'h7, "sleep keeps");
    watch(30);
    chk(32'(tog > 0), 32'h1, "reference runs in sleep");
    wake(1'b0);
    chk(32'(wake_at > 0), 32'h1, "interrupt wakes sleep");
    chk({cpu_clk_en_o, sysclk_en_o, onchip_osc_en_o, periph_clk_en_o}, 32'hf, "clock restored");
    axi_wr(RCS_ADDR_PWR_CTRL, 32'h31, 4'h1);
    axi_wr(RCS_ADDR_REFOUT_CTRL, refv(1'b1, 1'b0, 1'b1, 4'h1), 4'h2);
    save(1'b0, 1'b0);
    watch(20);
    chk({posc_en_o, reference_clock_pin_o, regulator_en_o, low_power_rc_osc_en_o} | 32'(tog),
      32'h1, "sleep no output");
    wake(1'b1);
    chk(32'(wake_at > REG_WAKE), 32'h1, "regulator wake delay");
    chk({sysclk_en_o, onchip_osc_en_o, regulator_en_o}, 32'h7, "sleep exit state");
    $display("test sleep done");
    axi_wr(RCS_ADDR_PWR_CTRL, 32'h07, 4'h1);
    axi_wr(RCS_ADDR_REFOUT_CTRL, refv(1'b1, 1'b0, 1'b0, 4'h0), 4'h2);
    save(1'b1, 1'b0);
    chk({31'h0, clr_seen}, 32'h1, "watchdog cleared on idle");
    chk({cpu_clk_en_o, sysclk_en_o, periph_clk_en_o}, 32'h3, "idle gating");
    wake(1'b0);
    chk(32'(wake_at), 32'h1, "idle wake latency");
    chk({31'h0, cpu_clk_en_o}, 32'h1, "cpu clock back");
    axi_wr(RCS_ADDR_PWR_CTRL, 32'h06, 4'h1);
    save(1'b1, 1'b0);
    chk({31'h0, low_power_rc_osc_en_o}, 32'h1, "rc kept for monitor");
    wake(1'b1);
    chk(32'(wake_at > 0), 32'h1, "watchdog wakes idle");
    save(1'b1, 1'b1);
    chk({30'h0, cpu_off_seen, 1'b0} | 32'(wake_at > 0), 32'h3, "deferred interrupt");
    $display("test idle done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
